// [shared/mii_pkg.sv]
// constants and types shared by the mii receive and transmit port
package mii_pkg;
	localparam int unsigned CORE_CLK_HZ  = 25_000_000;
	localparam int unsigned RATE_10_HZ   = 2_500_000;
	localparam int unsigned RATE_100_HZ  = 25_000_000;
	localparam int unsigned DIV_W        = 4;
	localparam logic [3:0]  DIV_10       = 4'(CORE_CLK_HZ / RATE_10_HZ);
	localparam logic [3:0]  DIV_100      = 4'(CORE_CLK_HZ / RATE_100_HZ);
	localparam int unsigned NIB_W        = 4;
	localparam int unsigned FIFO_DEPTH   = 4;
	localparam logic [3:0]  NIB_ZERO     = 4'h0;

	typedef enum logic [3:0] {
		MII_RX_IDLE  = 4'h1,
		MII_RX_CARR  = 4'h2,
		MII_RX_FRAME = 4'h4,
		MII_RX_FALSE = 4'h8
	} mii_rx_state_e;
endpackage : mii_pkg

// [src/mii_nib_fifo.sv]
// small nibble fifo with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module mii_nib_fifo #(
	parameter int unsigned W     = 4,
	parameter int unsigned DEPTH = 4
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         clear,
	// fill side
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	// drain side
	output logic              out_valid,
	output logic [W-1:0]      out_data,
	input  wire logic         out_ready
);
	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int unsigned CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
	localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

	logic [W-1:0]  mem_reg [DEPTH];
	logic [AW-1:0] wr_reg;
	logic [AW-1:0] rd_reg;
	logic [CW-1:0] cnt_reg;
	logic [CW-1:0] cnt_next;
	logic          push;
	logic          pop;

	function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
		wrap_inc = (p == LAST_IDX) ? '0 : p + 1'b1;
	endfunction : wrap_inc

	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_valid = (cnt_reg != '0);
	assign out_data  = mem_reg[rd_reg];
	assign cnt_next  = cnt_reg + CW'(push) - CW'(pop);

	always_ff @(posedge clk) begin
		if (rst || clear) begin
			wr_reg   <= '0;
			rd_reg   <= '0;
			cnt_reg  <= '0;
			in_ready <= 1'b1;
		end else begin
			if (push) begin
				mem_reg[wr_reg] <= in_data;
				wr_reg          <= wrap_inc(wr_reg);
			end
			if (pop)
				rd_reg <= wrap_inc(rd_reg);
			cnt_reg  <= cnt_next;
			in_ready <= (cnt_next != FULL_CNT);
		end
	end
endmodule : mii_nib_fifo
`default_nettype wire

// [src/mii_clk_div.sv]
// divider giving one-cycle mii clock edge strobes with phase realign
`timescale 1ns/10ps
`default_nettype none
module mii_clk_div
	import mii_pkg::*;
(
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// control
	input  wire logic [DIV_W-1:0] div,
	input  wire logic             realign,
	// strobe
	output logic                  tick
);
	logic [DIV_W-1:0] cnt_reg;

	// realign restarts the phase, so one period may stretch
	always_ff @(posedge clk) begin
		if (rst || realign) begin
			cnt_reg <= '0;
			tick    <= 1'b0;
		end else if (cnt_reg >= div - 1'b1) begin
			cnt_reg <= '0;
			tick    <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 1'b1;
			tick    <= 1'b0;
		end
	end
endmodule : mii_clk_div
`default_nettype wire

// [src/mii_phy_port.sv]
// mii port of a 10/100 phy facing the mac
// Operation
// - 10 Mb/s receive clock runs at 2.5 MHz.
// - 10 Mb/s receive clock tracks line, free-runs on last packet phase.
// - 10 Mb/s clock source switches after carrier, before receive-valid; here the source stays line and the phase realigns at carrier instead.
// - 10 Mb/s receive clock realigns once per packet.
// - 100 Mb/s receive clock 25 MHz, from line with link, else reference.
// - 100 Mb/s receive clock realigns once, when link comes up; here it also realigns on each speed change.
// - receive nibble bit 0 is lsb, bit 3 is msb.
// - nibbles and receive-valid change only on receive clock edges.
// - receive-valid rises only after start delimiter found.
// - receive-valid drops on end delimiter or signal error.
// - receive error stays low at 10 Mb/s.
// - 100 Mb/s receive error on frame errors and false carrier.
// - receive error changes only on receive clock edges.
// - receive clock and error outputs gated by float control pin.
// - transmit clock is 2.5 MHz or 25 MHz by speed.
// - with enable high, nibble sampled each transmit clock edge.
// - enable low stops nibbles to the medium.
`timescale 1ns/10ps
`default_nettype none
module mii_phy_port
	import mii_pkg::*;
(
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             rst,
	// mode and line status
	input  wire logic             speed_100,
	input  wire logic             link_ok,
	input  wire logic             receive_output_float_control,
	// line decoder events
	input  wire logic             line_carrier,
	input  wire logic             line_ssd,
	input  wire logic             line_esd,
	input  wire logic             line_sig_err,
	input  wire logic             line_code_err,
	input  wire logic             line_false_carrier,
	// line nibble stream
	input  wire logic             line_nib_valid,
	input  wire logic [NIB_W-1:0] line_nib,
	output logic                  line_nib_ready,
	// mac receive side
	output logic                  rx_clk,
	output logic                  rx_clk_oe_n,
	output logic                  rx_clk_from_line,
	output logic [NIB_W-1:0]      rxd,
	output logic                  rx_dv,
	output logic                  rx_er,
	output logic                  rx_er_oe_n,
	// mac transmit side
	output logic                  tx_clk,
	input  wire logic             mii_tx_en,
	input  wire logic [NIB_W-1:0] mii_txd,
	// medium side
	output logic [NIB_W-1:0]      med_nib,
	output logic                  med_nib_valid
);
	mii_rx_state_e    state_reg;
	mii_rx_state_e    state_next;
	logic             speed_q_reg;
	logic             link_q_reg;
	logic             err_pend_reg;
	logic             rx_clk_reg;
	logic             tx_clk_reg;
	logic [NIB_W-1:0] rxd_reg;
	logic             rx_dv_reg;
	logic             rx_er_reg;
	logic             float_reg;
	logic             src_line_reg;
	logic [NIB_W-1:0] med_nib_reg;
	logic             med_valid_reg;

	logic             rx_tick;
	logic             tx_tick;
	logic [DIV_W-1:0] div_sel;
	logic             speed_chg;
	logic             rx_realign;
	logic             in_frame;
	logic             frame_end;
	logic             fifo_valid;
	logic [NIB_W-1:0] fifo_data;
	logic             fifo_pop;
	logic             fifo_push;
	logic             dv_next;
	logic [NIB_W-1:0] rxd_next;
	logic             er_next;

	// one divider per direction; speed picks the ratio
	assign div_sel   = speed_100 ? DIV_100 : DIV_10;
	assign speed_chg = (speed_100 != speed_q_reg);
	// 10M realigns as carrier opens a packet, ahead of any valid
	// 100M at link-up and on a speed change, so frames never see a phase jump
	assign rx_realign = speed_chg
		|| (!speed_100 && state_reg == MII_RX_IDLE && line_carrier)
		|| (speed_100 && link_ok && !link_q_reg);

	mii_clk_div u_rx_div (
		.clk     (core_clk),
		.rst     (rst),
		.div     (div_sel),
		.realign (rx_realign),
		.tick    (rx_tick)
	);

	mii_clk_div u_tx_div (
		.clk     (core_clk),
		.rst     (rst),
		.div     (div_sel),
		.realign (speed_chg),
		.tick    (tx_tick)
	);

	assign in_frame  = (state_reg == MII_RX_FRAME);
	assign frame_end = in_frame && (line_esd || line_sig_err);
	assign fifo_push = line_nib_valid && in_frame;
	assign fifo_pop  = rx_tick && in_frame && fifo_valid;

	// nibbles outside a frame are taken and dropped
	mii_nib_fifo #(
		.W     (NIB_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (core_clk),
		.rst       (rst),
		.clear     (frame_end),
		.in_valid  (fifo_push),
		.in_data   (line_nib),
		.in_ready  (line_nib_ready),
		.out_valid (fifo_valid),
		.out_data  (fifo_data),
		.out_ready (fifo_pop)
	);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			MII_RX_IDLE: begin
				if (line_carrier)
					state_next = MII_RX_CARR;
			end
			MII_RX_CARR: begin
				if (!line_carrier)
					state_next = MII_RX_IDLE;
				else if (line_ssd)
					state_next = MII_RX_FRAME;
				else if (line_false_carrier)
					state_next = MII_RX_FALSE;
			end
			MII_RX_FRAME: begin
				if (frame_end)
					state_next = MII_RX_IDLE;
			end
			MII_RX_FALSE: begin
				if (!line_carrier)
					state_next = MII_RX_IDLE;
			end
			default: state_next = MII_RX_IDLE;
		endcase
	end

	// underrun inside a frame holds the last nibble with valid high
	assign dv_next  = in_frame && (fifo_valid || rx_dv_reg);
	assign rxd_next = fifo_pop ? fifo_data :
		(dv_next ? rxd_reg : NIB_ZERO);
	assign er_next  = speed_100 && ((state_reg == MII_RX_FALSE)
		|| (in_frame && err_pend_reg));

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_reg   <= MII_RX_IDLE;
			speed_q_reg <= 1'b0;
			link_q_reg  <= 1'b0;
		end else begin
			state_reg   <= state_next;
			speed_q_reg <= speed_100;
			link_q_reg  <= link_ok;
		end
	end

	// error seen between edges waits for the next edge; set wins
	always_ff @(posedge core_clk) begin
		if (rst)
			err_pend_reg <= 1'b0;
		else if (in_frame && line_code_err)
			err_pend_reg <= 1'b1;
		else if (rx_tick || !in_frame)
			err_pend_reg <= 1'b0;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rxd_reg   <= NIB_ZERO;
			rx_dv_reg <= 1'b0;
			rx_er_reg <= 1'b0;
		end else if (rx_tick) begin
			rxd_reg   <= rxd_next;
			rx_dv_reg <= dv_next;
			rx_er_reg <= er_next;
		end
	end

	// 10M pll keeps last packet phase, so it always counts as line
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rx_clk_reg   <= 1'b0;
			tx_clk_reg   <= 1'b0;
			float_reg    <= 1'b1;
			src_line_reg <= 1'b0;
		end else begin
			rx_clk_reg   <= rx_tick;
			tx_clk_reg   <= tx_tick;
			float_reg    <= receive_output_float_control;
			src_line_reg <= speed_100 ? link_ok : 1'b1;
		end
	end

	// mac drives bit 0 as lsb, kept in order to the medium
	always_ff @(posedge core_clk) begin
		if (rst) begin
			med_nib_reg   <= NIB_ZERO;
			med_valid_reg <= 1'b0;
		end else if (tx_tick) begin
			med_nib_reg   <= mii_tx_en ? mii_txd : NIB_ZERO;
			med_valid_reg <= mii_tx_en;
		end else begin
			med_valid_reg <= 1'b0;
		end
	end

	assign rx_clk           = rx_clk_reg;
	assign rx_clk_oe_n      = float_reg;
	assign rx_clk_from_line = src_line_reg;
	assign rxd              = rxd_reg;
	assign rx_dv            = rx_dv_reg;
	assign rx_er            = rx_er_reg;
	assign rx_er_oe_n       = float_reg;
	assign tx_clk           = tx_clk_reg;
	assign med_nib          = med_nib_reg;
	assign med_nib_valid    = med_valid_reg;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	AST_RXD_ZERO: assert property (!rx_dv_reg |-> rxd_reg == NIB_ZERO)
		else $error("rxd not zero while valid low");
	AST_DV_SYNC: assert property ($changed(rx_dv_reg) |-> $past(rx_tick))
		else $error("valid changed off a receive edge");
	AST_ER_SYNC: assert property ($changed(rx_er_reg) |-> $past(rx_tick))
		else $error("error changed off a receive edge");
	AST_DV_AFTER_SSD: assert property ($rose(rx_dv_reg) |-> $past(in_frame))
		else $error("valid rose without start delimiter");
	// first receive edge outside a frame must already show valid low
	AST_DV_DROP: assert property (rx_tick && !in_frame |=> !rx_dv_reg)
		else $error("valid not dropped after end of stream");
	AST_ER_10M: assert property (rx_tick && !speed_100 |=> !rx_er_reg)
		else $error("receive error raised at 10M");
	AST_FALSE_ER: assert property (
		rx_tick && speed_100 && state_reg == MII_RX_FALSE |=> rx_er_reg)
		else $error("false carrier not flagged");
	AST_CODE_ER: assert property (
		rx_tick && speed_100 && in_frame && err_pend_reg |=> rx_er_reg)
		else $error("frame error not flagged");
	AST_FLOAT: assert property (
		receive_output_float_control |=> rx_clk_oe_n && rx_er_oe_n)
		else $error("outputs not floated");
	AST_DRIVE: assert property (
		!receive_output_float_control |=> !rx_clk_oe_n && !rx_er_oe_n)
		else $error("outputs floated while control low");
	AST_TX_100: assert property (
		speed_100 && $past(speed_100) && $past(speed_100, 2)
		&& $past(speed_100, 3) |-> tx_clk_reg)
		else $error("tx clock not at full rate in 100M");
	AST_TX_10M: assert property (tx_tick && !speed_100 |=> !tx_tick)
		else $error("transmit clock too fast at 10M");
	AST_RX_10M: assert property (rx_tick && !speed_100 |=> !rx_tick)
		else $error("receive clock too fast at 10M");
	// three cycles after link-up the realigned divider strobes every cycle
	AST_RX_100: assert property (
		speed_100 && $past(speed_100) && $past(speed_100, 2)
		&& $past(speed_100, 3) && link_ok && $past(link_ok)
		&& $past(link_ok, 2) && $past(link_ok, 3) |-> rx_clk_reg)
		else $error("rx clock not at full rate in 100M");
	AST_SRC_10M: assert property (!speed_100 |=> rx_clk_from_line)
		else $error("10M clock not taken from the line pll");
	AST_SRC_100: assert property (
		speed_100 && !link_ok |=> !rx_clk_from_line)
		else $error("100M clock not on reference without link");
	// underrun must not show a new nibble nor drop valid mid-frame
	AST_RXD_HOLD: assert property (
		rx_tick && in_frame && rx_dv_reg && !fifo_valid
		|=> rx_dv_reg && $stable(rxd_reg))
		else $error("underrun changed receive nibble or valid");
	AST_TX_SAMPLE: assert property (
		mii_tx_en && tx_tick |=> med_nib_valid && med_nib == $past(mii_txd))
		else $error("transmit nibble not sampled");
	AST_TX_STOP: assert property (!mii_tx_en && tx_tick |=> !med_nib_valid)
		else $error("nibble sent with enable low");

	COV_FRAME: cover property ($rose(rx_dv_reg) ##[1:200] $fell(rx_dv_reg));
	COV_10M_FRAME: cover property ($rose(rx_dv_reg) && !speed_100);
	COV_FALSE: cover property ($rose(rx_er_reg) && !rx_dv_reg);
	COV_CODE_ER: cover property (rx_er_reg && rx_dv_reg);
	COV_TX: cover property (med_nib_valid ##[1:20] med_nib_valid);
endmodule : mii_phy_port
`default_nettype wire

// [testbench/mii_mac_model.sv]
// mac-side model: drives transmit nibbles, collects receive nibbles
`timescale 1ns/10ps
`default_nettype none
module mii_mac_model
	import mii_pkg::*;
(
	// clock
	input  wire logic             clk,
	// receive side from the phy
	input  wire logic             rx_clk,
	input  wire logic             rx_dv,
	input  wire logic [NIB_W-1:0] rxd,
	// transmit side to the phy
	input  wire logic             tx_clk,
	output logic                  tx_en,
	output logic [NIB_W-1:0]      txd
);
	logic [NIB_W-1:0] tx_q[$];
	logic [NIB_W-1:0] rx_q[$];
	initial begin
		tx_en = 1'b0;
		txd = 4'hA;
	end
	// change only just after a transmit clock edge, then hold a period
	always @(negedge clk) begin
		if (rx_clk && rx_dv)
			rx_q.push_back(rxd);
		if (tx_clk) begin
			tx_en <= (tx_q.size() > 0);
			// idle data toggles so stale nibbles never look valid
			txd <= (tx_q.size() > 0) ? tx_q.pop_front() : ~txd;
		end
	end
endmodule : mii_mac_model
`default_nettype wire

// [testbench/testbench.sv]
// self-checking bench for the mii phy port
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import mii_pkg::*;
	logic             core_clk, rst, speed_100, link_ok, float_ctl;
	logic             carrier, ssd, esd, sig_err, code_err, false_car;
	logic             nib_valid, nib_ready, rx_clk, rx_oe_n, from_line;
	logic             rx_dv, rx_er, er_oe_n, tx_clk, tx_en, med_valid;
	logic             dv_last;
	logic [NIB_W-1:0] nib, rxd, txd, med_nib;
	logic [NIB_W-1:0] exp_q[$], med_q[$];
	int               num_errors, cmp_count, cyc, rx_gap, tx_gap, er_cnt;

	mii_phy_port DUT (.core_clk(core_clk), .rst(rst),
		.speed_100(speed_100), .link_ok(link_ok),
		.receive_output_float_control(float_ctl),
		.line_carrier(carrier), .line_ssd(ssd), .line_esd(esd),
		.line_sig_err(sig_err), .line_code_err(code_err),
		.line_false_carrier(false_car), .line_nib_valid(nib_valid),
		.line_nib(nib), .line_nib_ready(nib_ready), .rx_clk(rx_clk),
		.rx_clk_oe_n(rx_oe_n), .rx_clk_from_line(from_line), .rxd(rxd),
		.rx_dv(rx_dv), .rx_er(rx_er), .rx_er_oe_n(er_oe_n),
		.tx_clk(tx_clk), .mii_tx_en(tx_en), .mii_txd(txd),
		.med_nib(med_nib), .med_nib_valid(med_valid));
	mii_mac_model mac (.clk(core_clk), .rx_clk(rx_clk), .rx_dv(rx_dv),
		.rxd(rxd), .tx_clk(tx_clk), .tx_en(tx_en), .txd(txd));

	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	task automatic check(string name, logic [3:0] seen, logic [3:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic end_of_test();
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test

	task automatic tick(int n);
		repeat (n) @(negedge core_clk);
	endtask : tick

	function automatic logic [3:0] gap_of(logic s100);
		return s100 ? 4'h1 : 4'hA;
	endfunction : gap_of

	// receive frame; junk offered before the start delimiter must vanish
	task automatic frame(int n, logic by_err, logic bad_nib);
		logic [3:0] v;
		exp_q = {};
		mac.rx_q = {};
		er_cnt = 0;
		carrier = 1'b1;
		nib = 4'hF;
		nib_valid = 1'b1;
		tick(3);
		check("dv before ssd", {3'h0, rx_dv}, 4'h0);
		nib_valid = 1'b0;
		ssd = 1'b1;
		tick(1);
		ssd = 1'b0;
		for (int i = 0; i < n; i++) begin
			v = (i == 0) ? 4'h1 : (i == 1) ? 4'h8 : 4'($urandom);
			exp_q.push_back(v);
			nib = v;
			nib_valid = 1'b1;
			code_err = bad_nib && (i == 2);
			while (nib_ready !== 1'b1)
				tick(1);
			tick(1);
		end
		nib_valid = 1'b0;
		code_err = 1'b0;
		// let the fifo drain, the end delimiter or signal error clears it
		tick(60);
		sig_err = by_err;
		esd = !by_err;
		tick(1);
		sig_err = 1'b0;
		esd = 1'b0;
		tick(25);
		check("dv after end", {3'h0, rx_dv}, 4'h0);
		for (int i = 0; i < n; i++)
			check("rx nibble", mac.rx_q[i], exp_q[i]);
		check("er strobes", 4'(er_cnt), {3'h0, bad_nib & speed_100});
		carrier = 1'b0;
		tick(5);
	endtask : frame

	task automatic send_tx(int n);
		logic [3:0] v;
		exp_q = {};
		med_q = {};
		for (int i = 0; i < n; i++) begin
			v = 4'($urandom);
			exp_q.push_back(v);
			mac.tx_q.push_back(v);
		end
		tick(12 * n + 30);
		check("tx count", 4'(med_q.size()), 4'(n));
		for (int i = 0; i < n; i++)
			check("med nibble", med_q[i], exp_q[i]);
	endtask : send_tx

	always @(negedge core_clk) begin
		if (!rst) begin
			if (rx_dv !== 1'b1)
				check("rxd idle", rxd, 4'h0);
			if (!speed_100)
				check("rx_er 10M", {3'h0, rx_er}, 4'h0);
			rx_gap++;
			tx_gap++;
			if (rx_clk) begin
				if (rx_dv && dv_last)
					check("rx gap", rx_gap[3:0], gap_of(speed_100));
				er_cnt += rx_er;
				dv_last = rx_dv;
				rx_gap = 0;
			end
			if (tx_clk) begin
				if (tx_en)
					check("tx gap", tx_gap[3:0], gap_of(speed_100));
				tx_gap = 0;
			end
			if (med_valid)
				med_q.push_back(med_nib);
		end
	end

	// hang guard well above the longest sequence
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			end_of_test();
		end
	end

	initial begin
		void'($urandom(32'h2db8));
		rst = 1'b1;
		dv_last = 1'b0;
		{speed_100, link_ok, float_ctl, carrier, ssd, esd} = '0;
		{sig_err, code_err, false_car, nib_valid} = '0;
		nib = 4'h0;
		tick(12);
		rst = 1'b0;
		tick(1);
		check("ready after reset", {3'h0, nib_ready}, 4'h1);
		float_ctl = 1'b1;
		tick(3);
		check("float", {2'h0, rx_oe_n, er_oe_n}, 4'h3);
		float_ctl = 1'b0;
		tick(3);
		check("drive", {2'h0, rx_oe_n, er_oe_n}, 4'h0);
		check("source 10M", {3'h0, from_line}, 4'h1);
		frame(12, 1'b0, 1'b1);
		send_tx(6);
		speed_100 = 1'b1;
		tick(5);
		check("source no link", {3'h0, from_line}, 4'h0);
		link_ok = 1'b1;
		tick(5);
		check("source link", {3'h0, from_line}, 4'h1);
		frame(20, 1'b1, 1'b1);
		frame(16, 1'b0, 1'b0);
		carrier = 1'b1;
		tick(1);
		false_car = 1'b1;
		tick(1);
		false_car = 1'b0;
		tick(5);
		check("false carrier", {2'h0, rx_er, rx_dv}, 4'h2);
		carrier = 1'b0;
		tick(5);
		check("er after carrier", {3'h0, rx_er}, 4'h0);
		send_tx(10);
		end_of_test();
	end
endmodule : testbench
`default_nettype wire
